// ===== design/i2cms_top.sv
// Transaction sequencer top: control and status bits, data register, link engine
`timescale 1ns/1ps
module i2cms_top
  import i2cms_pkg::*;
#(
  parameter int QUARTER = QUARTER_CYCLES
) (
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire logic              link_clock,
  input  wire logic              controller_enable,
  input  wire logic              transmit_irq_enable,
  input  wire logic              start_set,
  input  wire logic              stop_set,
  input  wire logic              flush,
  input  wire logic              last_byte_nak,
  input  wire logic              data_wr,
  input  wire logic [BYTE_W-1:0] data_wdata,
  input  wire logic              data_rd,
  output logic      [BYTE_W-1:0] data_rdata,
  output logic                   tx_data_empty,
  output logic                   rx_data_full,
  output logic                   ack_status,
  output logic                   no_ack_irq_flag,
  output logic                   start_pending,
  output logic                   stop_pending,
  output logic                   irq,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe,
  input  wire logic              scl_i,
  output logic                   scl_o,
  output logic                   scl_oe
);
  typedef enum logic [2:0] {
    CS_IDLE, CS_START, CS_WRITE, CS_NEXT, CS_READ, CS_RWAIT, CS_HOLD, CS_STOP
  } i2cms_cs_t;

  i2cms_cmd_if cmd ();

  i2cms_cs_t         state_q, state_d;
  logic [BYTE_W-1:0] data_q, data_d, txb_q, txb_d;
  logic              tx_empty_q, tx_empty_d, rx_full_q, rx_full_d;
  logic              ack_q, ack_d, nack_q, nack_d;
  logic              start_q, start_d, stop_q, stop_d;
  logic              rd_mode_q, rd_mode_d, addr_q, addr_d;
  logic              irq_q, irq_d, req_tgl_q, req_tgl_d, nakb_q, nakb_d;
  i2cms_cmd_t        kind_q, kind_d;
  logic              done_prev_q, done_prev_d, first_prev_q, first_prev_d;
  logic [1:0]        ans_s;
  logic              done_ev, first_ev;
  logic              go;
  i2cms_cmd_t        go_kind;
  logic [BYTE_W-1:0] go_byte;

  i2cms_link #(.QUARTER(QUARTER)) u_link (
    .clock  (link_clock),
    .reset  (reset),
    .cmd    (cmd.link),
    .sda_i  (sda_i),
    .sda_o  (sda_o),
    .sda_oe (sda_oe),
    .scl_i  (scl_i),
    .scl_o  (scl_o),
    .scl_oe (scl_oe)
  );

  i2cms_sync #(.W(2), .INIT(2'h0)) u_ans_sync (
    .clock (clock),
    .reset (reset),
    .d     ({cmd.first_tgl, cmd.done_tgl}),
    .q     (ans_s)
  );

  assign done_ev  = ans_s[0] ^ done_prev_q;
  assign first_ev = ans_s[1] ^ first_prev_q;

  always_comb
  begin
    state_d = state_q; data_d = data_q; txb_d = txb_q;
    tx_empty_d = tx_empty_q; rx_full_d = rx_full_q;
    ack_d = ack_q; nack_d = nack_q; start_d = start_q; stop_d = stop_q;
    rd_mode_d = rd_mode_q; addr_d = addr_q;
    req_tgl_d = req_tgl_q; nakb_d = nakb_q; kind_d = kind_q;
    done_prev_d = ans_s[0];
    first_prev_d = ans_s[1];
    go = 1'b0;
    go_kind = CMD_START;
    go_byte = data_q;
    if (data_rd)
      rx_full_d = 1'b0;
    if (data_wr)
    begin
      data_d = data_wdata;
      tx_empty_d = 1'b0;
    end
    if (flush)
      tx_empty_d = 1'b1;
    if (first_ev)
      tx_empty_d = 1'b1;
    unique case (state_q)
      CS_IDLE:
        if (controller_enable && start_q)
        begin
          go = 1'b1;
          go_kind = CMD_START;
          state_d = CS_START;
        end
      CS_START:
        if (done_ev)
        begin
          start_d = 1'b0;
          addr_d = 1'b1;
          rd_mode_d = data_q[RW_POS];
          go = 1'b1;
          go_kind = CMD_WRITE;
          state_d = CS_WRITE;
        end
      CS_WRITE:
        if (done_ev)
        begin
          addr_d = 1'b0;
          ack_d = cmd.ack_seen;
          if (!cmd.ack_seen && !stop_q && !start_q)
          begin
            nack_d = 1'b1;
            state_d = CS_HOLD;
          end
          else if (addr_q && rd_mode_q && cmd.ack_seen && !stop_q && !start_q)
          begin
            go = 1'b1;
            go_kind = CMD_READ;
            state_d = CS_READ;
          end
          else
            state_d = CS_NEXT;
        end
      CS_NEXT:
        if (stop_q)
        begin
          go = 1'b1;
          go_kind = CMD_STOP;
          state_d = CS_STOP;
        end
        else if (start_q)
        begin
          go = 1'b1;
          go_kind = CMD_START;
          state_d = CS_START;
        end
        else if (!tx_empty_q)
        begin
          go = 1'b1;
          go_kind = CMD_WRITE;
          state_d = CS_WRITE;
        end
      CS_READ:
        if (done_ev)
        begin
          data_d = cmd.rx_byte;
          rx_full_d = 1'b1;
          if (nakb_q)
          begin
            nack_d = 1'b1;
            state_d = CS_HOLD;
          end
          else
            state_d = CS_RWAIT;
        end
      CS_RWAIT:
        if (stop_q)
        begin
          go = 1'b1;
          go_kind = CMD_STOP;
          state_d = CS_STOP;
        end
        else if (!rx_full_q)
        begin
          go = 1'b1;
          go_kind = CMD_READ;
          state_d = CS_READ;
        end
      CS_HOLD:
        if (stop_q)
        begin
          go = 1'b1;
          go_kind = CMD_STOP;
          state_d = CS_STOP;
        end
        else if (start_q)
        begin
          go = 1'b1;
          go_kind = CMD_START;
          state_d = CS_START;
        end
      CS_STOP:
        if (done_ev)
        begin
          stop_d = 1'b0;
          nack_d = 1'b0;
          state_d = CS_IDLE;
        end
    endcase
    if (go)
    begin
      req_tgl_d = ~req_tgl_q;
      kind_d = go_kind;
      txb_d = go_byte;
      nakb_d = last_byte_nak;
    end
    if (start_set)
      start_d = 1'b1;
    if (stop_set)
      stop_d = 1'b1;
    irq_d = controller_enable
            && ((transmit_irq_enable && tx_empty_q) || rx_full_q || nack_q);
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state_q <= CS_IDLE; data_q <= DATA_RESET; txb_q <= DATA_RESET;
      tx_empty_q <= TX_EMPTY_RESET; rx_full_q <= 1'b0;
      ack_q <= 1'b0; nack_q <= 1'b0; start_q <= 1'b0; stop_q <= 1'b0;
      rd_mode_q <= 1'b0; addr_q <= 1'b0; irq_q <= 1'b0;
      req_tgl_q <= 1'b0; nakb_q <= 1'b0; kind_q <= CMD_START;
      done_prev_q <= 1'b0; first_prev_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d; data_q <= data_d; txb_q <= txb_d;
      tx_empty_q <= tx_empty_d; rx_full_q <= rx_full_d;
      ack_q <= ack_d; nack_q <= nack_d; start_q <= start_d; stop_q <= stop_d;
      rd_mode_q <= rd_mode_d; addr_q <= addr_d; irq_q <= irq_d;
      req_tgl_q <= req_tgl_d; nakb_q <= nakb_d; kind_q <= kind_d;
      done_prev_q <= done_prev_d; first_prev_q <= first_prev_d;
    end
  end

  assign cmd.req_tgl      = req_tgl_q;
  assign cmd.kind         = kind_q;
  assign cmd.tx_byte      = txb_q;
  assign cmd.nak          = nakb_q;
  assign data_rdata       = data_q;
  assign tx_data_empty    = tx_empty_q;
  assign rx_data_full     = rx_full_q;
  assign ack_status       = ack_q;
  assign no_ack_irq_flag  = nack_q;
  assign start_pending    = start_q;
  assign stop_pending     = stop_q;
  assign irq              = irq_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence write_done_s;
    state_q == CS_WRITE && done_ev;
  endsequence

  sequence read_done_s;
    state_q == CS_READ && done_ev;
  endsequence

  tx_irq_a: assert property (
    controller_enable && transmit_irq_enable && tx_empty_q |=> irq_q)
    else $error("Transmit-empty interrupt missing");

  start_issue_a: assert property (
    state_q == CS_IDLE && controller_enable && start_q
    |=> state_q == CS_START && kind_q == CMD_START && req_tgl_q != $past(req_tgl_q))
    else $error("Start bit did not issue a start condition");

  first_bit_a: assert property (
    first_ev |=> tx_empty_q)
    else $error("Transmit-empty not set after first bit");

  ack_set_a: assert property (
    write_done_s ##0 cmd.ack_seen |=> ack_q)
    else $error("Acknowledge status not set");

  nack_flag_a: assert property (
    write_done_s ##0 (!cmd.ack_seen && !stop_q && !start_q)
    |=> nack_q && !ack_q && state_q == CS_HOLD)
    else $error("No-ack flag not raised");

  pend_no_nack_a: assert property (
    write_done_s ##0 ((stop_q || start_q) && !nack_q) |=> !nack_q ##1 !nack_q)
    else $error("No-ack raised with stop or start pending");

  stop_clear_a: assert property (
    state_q == CS_STOP && done_ev && !stop_set
    |=> !stop_q && !nack_q && state_q == CS_IDLE)
    else $error("Stop or no-ack flag not cleared after stop");

  restart_load_a: assert property (
    state_q == CS_START && done_ev && !start_set
    |=> !start_q && kind_q == CMD_WRITE && txb_q == $past(data_q))
    else $error("Start not cleared or shifter not loaded");

  next_load_a: assert property (
    state_q == CS_NEXT && !stop_q && !start_q && !tx_empty_q
    |=> state_q == CS_WRITE && txb_q == $past(data_q))
    else $error("Next byte not loaded");

  rx_full_a: assert property (
    read_done_s |=> rx_full_q && data_q == $past(cmd.rx_byte))
    else $error("Receive-full not set on received byte");

  rx_clear_a: assert property (
    rx_full_q && data_rd && !(state_q == CS_READ && done_ev) |=> !rx_full_q)
    else $error("Data read did not clear receive-full");

  read_nak_a: assert property (
    state_q == CS_RWAIT && !stop_q && !rx_full_q
    |=> kind_q == CMD_READ && nakb_q == $past(last_byte_nak))
    else $error("Read issued with wrong NAK choice");

  last_nack_a: assert property (
    read_done_s ##0 nakb_q |=> nack_q && state_q == CS_HOLD)
    else $error("No-ack not raised after last received byte");
endmodule // i2cms_top

// ===== design/i2cms_pkg.sv
// Constants and types shared by the I2C master transaction sequencer
// What this block does
// - Enabled with transmit irq enable, interrupt rises whenever data register is empty.
// - Start bit makes a start condition, then data register loads the shifter.
// - After first address bit leaves, transmit-empty flag and interrupt rise.
// - Slave holding SDA low in ninth clock sets acknowledge status.
// - Unacknowledged byte, nothing pending: set no-ack flag, clear acknowledge status.
// - After no-ack with stop, send stop, then clear stop and no-ack flag.
// - Acknowledged first address: second address byte shifts, irq after first bit.
// - Every transmitted data byte raises transmit-empty after its first bit.
// - Stop or start already pending at last byte: no no-ack interrupt.
// - After last byte send pending stop or restart, then clear that bit.
// - Received byte answered with not-acknowledge if last-byte NAK set, else acknowledge.
// - Each received byte sets receive-full and raises the interrupt.
// - Reading the data register clears receive-full.
// - After final received byte raise no-ack; stop then sent, stop and flag cleared.
// - Shift register is hidden; it only buffers bytes between data register and bus.
package i2cms_pkg;
  localparam int         LINK_CLOCK_HZ  = 8_000_000;
  localparam int         BUS_RATE_HZ    = 100_000;
  localparam int         QUARTER_CYCLES = LINK_CLOCK_HZ / (4 * BUS_RATE_HZ);
  localparam int         QCNT_W         = 8;
  localparam int         BYTE_W         = 8;
  localparam int         MSB_POS        = 7;
  localparam int         RW_POS         = 0;
  localparam logic [3:0] FIRST_IDX      = 4'h0;
  localparam logic [3:0] LAST_DATA_IDX  = 4'h7;
  localparam logic [3:0] ACK_IDX        = 4'h8;
  localparam logic [1:0] PH_LOW         = 2'h0;
  localparam logic [1:0] PH_RISE        = 2'h1;
  localparam logic [1:0] PH_HIGH        = 2'h2;
  localparam logic [1:0] PH_FALL        = 2'h3;
  localparam logic [7:0] DATA_RESET     = 8'h00;
  localparam logic       TX_EMPTY_RESET = 1'b1;
  localparam logic       PIN_LOW        = 1'b0;
  typedef enum logic [1:0] {CMD_START, CMD_WRITE, CMD_READ, CMD_STOP} i2cms_cmd_t;
endpackage

// ===== design/i2cms_cmd_if.sv
// Command and answer signals between sequencer and link engine
`timescale 1ns/1ps
interface i2cms_cmd_if;
  import i2cms_pkg::*;
  logic              req_tgl;
  i2cms_cmd_t        kind;
  logic [BYTE_W-1:0] tx_byte;
  logic              nak;
  logic              done_tgl;
  logic              first_tgl;
  logic [BYTE_W-1:0] rx_byte;
  logic              ack_seen;
  modport ctl  (output req_tgl, kind, tx_byte, nak,
                input  done_tgl, first_tgl, rx_byte, ack_seen);
  modport link (input  req_tgl, kind, tx_byte, nak,
                output done_tgl, first_tgl, rx_byte, ack_seen);
endinterface

// ===== design/i2cms_sync.sv
// Two flip-flop synchroniser for level and toggle signals
`timescale 1ns/1ps
module i2cms_sync #(
  parameter int         W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clock,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] out_q;
  logic [W-1:0] out_d;

  always_comb
  begin
    meta_d = d;
    out_d  = meta_q;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      meta_q <= INIT;
      out_q  <= INIT;
    end
    else
    begin
      meta_q <= meta_d;
      out_q  <= out_d;
    end
  end

  assign q = out_q;
endmodule // i2cms_sync

// ===== design/i2cms_link.sv
// Bit engine on the link clock: start, stop, byte write and byte read
`timescale 1ns/1ps
module i2cms_link
  import i2cms_pkg::*;
#(
  parameter int QUARTER = QUARTER_CYCLES
) (
  input  wire logic  clock,
  input  wire logic  reset,
  i2cms_cmd_if.link  cmd,
  input  wire logic  sda_i,
  output logic       sda_o,
  output logic       sda_oe,
  input  wire logic  scl_i,
  output logic       scl_o,
  output logic       scl_oe
);
  typedef enum logic {LS_IDLE, LS_RUN} i2cms_ls_t;
  localparam logic [QCNT_W-1:0] QLAST = QCNT_W'(QUARTER - 1);

  i2cms_ls_t         state_q, state_d;
  logic [QCNT_W-1:0] cnt_q, cnt_d;
  logic [1:0]        ph_q, ph_d;
  logic [3:0]        idx_q, idx_d;
  logic [BYTE_W-1:0] shift_q, shift_d;
  logic              sda_oe_q, sda_oe_d, scl_oe_q, scl_oe_d;
  logic              ack_q, ack_d, req_prev_q, req_prev_d;
  logic              done_q, done_d, first_q, first_d, nak_q, nak_d;
  i2cms_cmd_t        kind_q, kind_d;
  logic              pin_low_q;
  logic [2:0]        in_s;
  logic              stall, tick;

  i2cms_sync #(.W(3), .INIT(3'h3)) u_in_sync (
    .clock (clock),
    .reset (reset),
    .d     ({cmd.req_tgl, scl_i, sda_i}),
    .q     (in_s)
  );

  // Slave holding SCL low after release stalls the counter, stretching the low phase
  assign stall = !scl_oe_q && !in_s[1];
  assign tick  = (cnt_q == QLAST) && !stall;

  always_comb
  begin
    state_d = state_q; cnt_d = cnt_q; ph_d = ph_q; idx_d = idx_q;
    shift_d = shift_q; sda_oe_d = sda_oe_q; scl_oe_d = scl_oe_q;
    ack_d = ack_q; req_prev_d = req_prev_q; done_d = done_q;
    first_d = first_q; kind_d = kind_q; nak_d = nak_q;
    if (state_q == LS_IDLE)
    begin
      if (in_s[2] != req_prev_q)
      begin
        req_prev_d = in_s[2];
        kind_d     = cmd.kind;
        nak_d      = cmd.nak;
        shift_d    = cmd.tx_byte;
        ph_d       = PH_LOW;
        idx_d      = FIRST_IDX;
        cnt_d      = '0;
        state_d    = LS_RUN;
        unique case (cmd.kind)
          CMD_START: sda_oe_d = 1'b0;
          CMD_STOP:  sda_oe_d = 1'b1;
          CMD_WRITE: sda_oe_d = ~cmd.tx_byte[MSB_POS];
          CMD_READ:  sda_oe_d = 1'b0;
        endcase
      end
    end
    else
    begin
      cnt_d = tick ? '0 : (stall ? cnt_q : cnt_q + QCNT_W'(1));
      if (tick)
      begin
        ph_d = ph_q + 2'h1;
        unique case (ph_q)
          PH_LOW: scl_oe_d = 1'b0;
          PH_RISE:
          begin
            if (kind_q == CMD_START)
              sda_oe_d = 1'b1;
            else if (kind_q == CMD_STOP)
              sda_oe_d = 1'b0;
            else if (kind_q == CMD_WRITE && idx_q == ACK_IDX)
              ack_d = ~in_s[0];
            else if (kind_q == CMD_READ && idx_q != ACK_IDX)
              shift_d = {shift_q[MSB_POS-1:0], in_s[0]};
          end
          PH_HIGH: if (kind_q != CMD_STOP) scl_oe_d = 1'b1;
          PH_FALL:
          begin
            if (kind_q == CMD_WRITE && idx_q == FIRST_IDX)
              first_d = ~first_q;
            if (kind_q == CMD_START || kind_q == CMD_STOP || idx_q == ACK_IDX)
            begin
              done_d  = ~done_q;
              state_d = LS_IDLE;
            end
            else
            begin
              idx_d = idx_q + 4'h1;
              if (kind_q == CMD_WRITE)
                shift_d = {shift_q[MSB_POS-1:0], 1'b0};
              if (idx_q == LAST_DATA_IDX)
                sda_oe_d = (kind_q == CMD_READ) ? ~nak_q : 1'b0;
              else
                sda_oe_d = (kind_q == CMD_WRITE) ? ~shift_q[MSB_POS-1] : 1'b0;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state_q <= LS_IDLE; cnt_q <= '0; ph_q <= PH_LOW; idx_q <= FIRST_IDX;
      shift_q <= DATA_RESET; sda_oe_q <= 1'b0; scl_oe_q <= 1'b0;
      ack_q <= 1'b0; req_prev_q <= 1'b0; done_q <= 1'b0;
      first_q <= 1'b0; kind_q <= CMD_START; nak_q <= 1'b0; pin_low_q <= PIN_LOW;
    end
    else
    begin
      state_q <= state_d; cnt_q <= cnt_d; ph_q <= ph_d; idx_q <= idx_d;
      shift_q <= shift_d; sda_oe_q <= sda_oe_d; scl_oe_q <= scl_oe_d;
      ack_q <= ack_d; req_prev_q <= req_prev_d; done_q <= done_d;
      first_q <= first_d; kind_q <= kind_d; nak_q <= nak_d; pin_low_q <= PIN_LOW;
    end
  end

  assign sda_o         = pin_low_q;
  assign scl_o         = pin_low_q;
  assign sda_oe        = sda_oe_q;
  assign scl_oe        = scl_oe_q;
  assign cmd.done_tgl  = done_q;
  assign cmd.first_tgl = first_q;
  assign cmd.rx_byte   = shift_q;
  assign cmd.ack_seen  = ack_q;
endmodule // i2cms_link

// ===== verif/i2cms_slave.sv
// Behavioural I2C slave: ack control, read data source, clock stretching
`timescale 1ns/1ps
module i2cms_slave (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       ack_en,
  input  wire logic       stretch,
  input  wire logic [7:0] base,
  output logic            sda_oe,
  output logic            scl_oe,
  output logic [7:0]      got,
  output logic            m_ack
);
  int         bit_n   = 0;
  int         nrd     = 0;
  logic       rd_mode = 1'b0;
  logic       first   = 1'b0;
  logic       go      = 1'b0;
  logic [7:0] cur     = 8'h00;
  logic [7:0] sh      = 8'h00;
  initial {sda_oe, scl_oe, got, m_ack} = 11'h000;
  // Start or repeated start
  always @(negedge sda)
    if (scl)
    begin
      bit_n = 0;
      nrd = 0;
      rd_mode = 1'b0;
      first = 1'b1;
    end
  // Stop
  always @(posedge sda)
    if (scl)
    begin
      bit_n = 0;
      rd_mode = 1'b0;
      first = 1'b0;
    end
  // Sampling while SCL rises
  always @(posedge scl)
  begin
    if (bit_n < 8 && !rd_mode)
      sh = {sh[6:0], sda};
    if (bit_n == 7 && !rd_mode)
      got = sh;
    if (bit_n == 8 && rd_mode)
    begin
      m_ack = !sda;
      go = m_ack;
    end
    bit_n++;
  end
  // Driving while SCL is low
  always @(negedge scl)
  begin
    if (bit_n == 8 && !rd_mode)
    begin
      sda_oe = ack_en;
      if (first && ack_en)
      begin
        rd_mode = got[0];
        go = 1'b1;
      end
      first = 1'b0;
    end
    else if (bit_n == 8)
      sda_oe = 1'b0;
    else if (bit_n == 9)
    begin
      bit_n = 0;
      cur = base + 8'(nrd);
      if (rd_mode && go)
        nrd++;
      sda_oe = rd_mode && go && !cur[7];
    end
    else if (rd_mode && bit_n > 0)
      sda_oe = !cur[7 - bit_n];
  end
  // Optional stretch of each low phase
  always @(negedge scl)
    if (stretch)
    begin
      scl_oe = 1'b1;
      #700 scl_oe = 1'b0;
    end
endmodule // i2cms_slave

// ===== verif/tb_i2c_master_transaction_sequencer.sv
// Self-checking testbench for the I2C master transaction sequencer
`timescale 1ns/1ps
module tb_i2c_master_transaction_sequencer;
  import i2cms_pkg::*;
  logic       clock = 0, reset = 1, link_clock = 0;
  logic       en = 0, txie = 0, st = 0, sp = 0, fl = 0, nak = 0, wr = 0, rd = 0;
  logic [7:0] wd = 8'h00, base = 8'h00, rdata, s_got;
  logic       txe, rxf, ack, nack, spp, stp, irq, sdoe, scoe;
  logic       s_sda_oe, s_scl_oe, m_ack, s_ack = 1, s_str = 0, so, co;
  logic [7:0] b [8];
  int         failures = 0, check_count = 0, n;
  wire        sda = !(sdoe | s_sda_oe);
  wire        scl = !(scoe | s_scl_oe);
  initial forever #12.5 clock = !clock;
  initial
  begin
    #7;
    forever #62.5 link_clock = !link_clock;
  end
  i2cms_top #(.QUARTER(2)) DUT (
    .clock(clock), .reset(reset), .link_clock(link_clock),
    .controller_enable(en), .transmit_irq_enable(txie), .start_set(st),
    .stop_set(sp), .flush(fl), .last_byte_nak(nak), .data_wr(wr),
    .data_wdata(wd), .data_rd(rd), .data_rdata(rdata), .tx_data_empty(txe),
    .rx_data_full(rxf), .ack_status(ack), .no_ack_irq_flag(nack),
    .start_pending(spp), .stop_pending(stp), .irq(irq), .sda_i(sda),
    .sda_o(so), .sda_oe(sdoe), .scl_i(scl), .scl_o(co), .scl_oe(scoe)
  );
  i2cms_slave slave (
    .scl(scl), .sda(sda), .ack_en(s_ack), .stretch(s_str), .base(base),
    .sda_oe(s_sda_oe), .scl_oe(s_scl_oe), .got(s_got), .m_ack(m_ack)
  );
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic sel(int w);
    case (w)
      0: return txe;
      1: return rxf;
      2: return nack;
      default: return stp;
    endcase
  endfunction
  task automatic wt(int w, logic v);
    int i;
    i = 0;
    while (sel(w) !== v && i < 40000)
    begin
      @(negedge clock);
      i++;
    end
    if (i == 40000)
    begin
      failures++;
      $display("MISMATCH wait %0d expected %b seen %b", w, v, sel(w));
      report_and_stop();
    end
  endtask
  task automatic pulse(logic s, logic p, logic f, logic r, logic w);
    @(negedge clock);
    {st, sp, fl, rd, wr} = {s, p, f, r, w};
    @(negedge clock);
    {st, sp, fl, rd, wr} = 5'h00;
  endtask
  task automatic write_txn(logic [9:0] a, int nd, int nk, logic rs);
    int m;
    m = nd + 2;
    b[0] = {5'h1E, a[9:8], 1'b0};
    b[1] = a[7:0];
    for (int k = 2; k < m; k++)
      b[k] = 8'($urandom);
    s_ack = 1;
    s_str = 1'($urandom);
    txie = 1;
    wd = b[0];
    pulse(0, 0, 0, 0, 1);
    pulse(1, 0, 0, 0, 0);
    for (int k = 0; k < m; k++)
    begin
      wt(0, 1);
      if (k == 0)
        chk("start", 0, spp);
      s_ack = (k != nk);
      if (k > 0)
        chk("byte", b[k-1], s_got);
      if (k > 0)
        chk("ack", 1, ack);
      if (k == nk && k < m - 1)
      begin
        wt(2, 1);
        chk("ack", 0, ack);
        chk("byte", b[k], s_got);
        pulse(0, 0, 0, 0, 1);
        chk("queued", 0, txe);
        txie = 0;
        pulse(0, 1, 1, 0, 0);
        wt(3, 0);
        chk("noack", 0, nack);
        chk("empty", 1, txe);
        return;
      end
      if (k == m - 1 && rs)
      begin
        txie = 0;
        read_txn(7'h2C, 2);
        return;
      end
      if (k == m - 1)
      begin
        txie = 0;
        pulse(0, 1, 0, 0, 0);
        wt(3, 0);
        chk("noack", 0, nack);
        chk("byte", b[k], s_got);
        chk("idle", 3, {scl, sda});
      end
      else
      begin
        wd = b[k+1];
        pulse(0, 0, 0, 0, 1);
      end
    end
  endtask
  task automatic read_txn(logic [6:0] a, int nr);
    base = 8'($urandom);
    s_ack = 1;
    s_str = 1'($urandom);
    nak = (nr == 1);
    wd = {a, 1'b1};
    pulse(0, 0, 0, 0, 1);
    pulse(1, 0, 0, 0, 0);
    for (int k = 0; k < nr; k++)
    begin
      wt(1, 1);
      if (k == 0)
        chk("start", 0, spp);
      chk("rxbyte", base + 8'(k), rdata);
      chk("master ack", k < nr - 1, m_ack);
      repeat (2) @(negedge clock);
      chk("irq", 1, irq);
      if (k == nr - 2)
        nak = 1;
      pulse(0, 0, 0, 1, 0);
      chk("full", 0, rxf);
    end
    wt(2, 1);
    pulse(0, 1, 0, 0, 0);
    wt(3, 0);
    chk("noack", 0, nack);
    nak = 0;
  endtask
  initial
  begin
    void'($urandom(78));
    repeat (20) @(negedge clock);
    reset = 0;
    en = 1;
    txie = 1;
    repeat (3) @(negedge clock);
    chk("empty", 1, txe);
    chk("irq", 1, irq);
    chk("rdata", 0, rdata);
    chk("pin level", 0, {so, co});
    write_txn(10'h2A5, 2, 9, 0);
    write_txn(10'h3C1, 1, 0, 0);
    write_txn(10'h155, 3, 1, 0);
    write_txn(10'h0F0, 1, 2, 0);
    write_txn(10'h1B7, 1, 9, 1);
    repeat (4)
    begin
      n = 1 + ($urandom % 3);
      write_txn(10'($urandom), n, $urandom % (n + 3), 0);
    end
    s_ack = 0;
    wd = 8'hA3;
    pulse(0, 0, 0, 0, 1);
    pulse(1, 0, 0, 0, 0);
    wt(2, 1);
    chk("ack", 0, ack);
    pulse(0, 1, 0, 0, 0);
    wt(3, 0);
    chk("noack", 0, nack);
    read_txn(7'h51, 1);
    repeat (3)
      read_txn(7'($urandom), 1 + ($urandom % 4));
    report_and_stop();
  end
endmodule // tb_i2c_master_transaction_sequencer
